// ### sfp_agent.sv
// Purpose: Writer and reader beside the FIFO, with its own reference.
// Assumes: Requests change 1 ns after a rising edge.
// Notes:   Notes each expected output word in exp_q.
`default_nettype none
module sfp_agent #(
   parameter int unsigned DEPTH = 64
) (
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   output var  logic [8:0] wd_o,
   output var  logic       wen_n_o,
   output var  logic       pin_o,
   output var  logic       first_read_enable_n_o,
   output var  logic       second_read_enable_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] offs [4];
   logic [1:0] sel;
   logic       prog;
   logic [8:0] last;
   int         cnt;
   logic [8:0] dq [$];
   logic [8:0] exp_q [$];
   wire logic  rd = !first_read_enable_n_o && !second_read_enable_n_o;
   // Idle controls from time zero.
   initial begin
      {wd_o, wen_n_o, pin_o, first_read_enable_n_o, second_read_enable_n_o} = 13'h000F;
   end
   // One request for the coming edge.
   task automatic step(input logic w, input logic p, input logic r1,
                       input logic r2, input logic [8:0] d);
      @(posedge clk_i);
      #1;
      {wen_n_o, pin_o, first_read_enable_n_o, second_read_enable_n_o, wd_o} = {w, p, r1, r2, d};
   endtask
   // Reference of each edge; pointers use pre-edge counts, as the block.
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         offs = '{8'h07, 8'h00, 8'h07, 8'h00};
         sel = 2'h0;
         last = 9'h000;
         dq.delete();
         exp_q.delete();
         prog = !pin_o;
      end else if (prog && !pin_o) begin
         if (!wen_n_o) begin // Never with a read-back
            offs[sel] = wd_o[7:0];
            sel++;
         end else if (rd) begin
            last = {1'b0, offs[sel]};
            exp_q.push_back(last);
            sel++;
         end
      end else begin
         if (rd && dq.size() > 0) last = dq.pop_front();
         if (rd) exp_q.push_back(last);
         if (!wen_n_o && pin_o && cnt < DEPTH) dq.push_back(wd_o);
      end
      cnt = dq.size();
   end
endmodule // sfp_agent
`default_nettype wire

// ### sfp_fifo.sv
// Purpose: 9-bit FIFO with full, empty and two programmable flags.
// Assumes: Writer and reader run on clk_i; controls need no sync.
// Notes:   The pin role is caught at the first edge after reset.
`default_nettype none

// Operation
// - Pin high at first edge after reset selects two enables
// - Enable pair active stores next word
// - Inactive enable pair writes nothing
// - Full flag blocks every array write
// - Read on full FIFO releases full flag
// - Pin low at first edge after reset selects offset mode
// - Load writes offsets in cyclic order
// - Pin high pauses load, keeps position
// - Load low with enable high does nothing
// - Read-back steps offsets in same order
// - Full offset low resets to seven
// - Full flag low at depth words
// - Full flag changes on write and read edges
// - Empty flag low when pointers match
// - Almost-full low at depth minus offset
// - Almost-empty low near empty offset
// - Reset clears pointers and output, presets flags and offsets
// - Enabled read loads next word out
module sfp_fifo
   import sfp_pkg::*;
#(
   parameter int unsigned DEPTH = SFP_DEPTH
) (
   input  wire logic                  clk_i,
   input  wire logic                  arst_n_i,
   input  wire logic [SFP_DATA_W-1:0] write_data_i,
   input  wire logic                  first_write_enable_n_i,
   input  wire logic                  second_enable_or_load_i,
   input  wire logic                  first_read_enable_n_i,
   input  wire logic                  second_read_enable_n_i,
   output logic      [SFP_DATA_W-1:0] read_data_o,
   output logic                       full_flag_n_o,
   output logic                       empty_flag_n_o,
   output logic                       almost_full_flag_n_o,
   output logic                       almost_empty_flag_n_o
);
   import sfp_pkg::*;

   // Address width and the count width one bit wider.
   localparam int unsigned AW = $clog2(DEPTH);
   localparam int unsigned CW = AW + 1;

   // Depth as a count-wide constant for the flag compares.
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

   // Complete state of the block.
   typedef struct packed {
      logic                  cfg_done;
      sfp_mode_t             mode;
      logic [CW-1:0]         wptr;
      logic [CW-1:0]         rptr;
      logic [SFP_DATA_W-1:0] rd_data;
      logic                  full_n;
      logic                  empty_n;
      logic                  afull_n;
      logic                  aempty_n;
   } sfp_st_t;

   sfp_st_t st_r;
   sfp_st_t st_nxt;

   // Decoded controls.
   logic                  wr_req;
   logic                  rd_req;
   logic                  pin_hi;
   logic                  prog_mode;
   logic                  load_sel;
   logic                  fifo_wr;
   logic                  fifo_rd;
   logic                  ofs_wr;
   logic                  ofs_rd;

   // Array and offset bank connections.
   logic [SFP_DATA_W-1:0] ram_rd_data;
   logic [SFP_OFFS_W-1:0] ofs_rd_data;
   logic [15:0]           empty_offset;
   logic [15:0]           full_offset;

   // Offsets cut to the array size.
   logic [AW-1:0]         empty_ofs;
   logic [AW-1:0]         full_ofs;
   logic [CW-1:0]         afull_level;

   // Pointers and fill level after this edge.
   logic [CW-1:0]         wptr_nxt;
   logic [CW-1:0]         rptr_nxt;
   logic [CW-1:0]         count_nxt;

   // Enables are active low, the dual-purpose pin active high.
   assign wr_req = !first_write_enable_n_i;
   assign rd_req = !first_read_enable_n_i && !second_read_enable_n_i;
   assign pin_hi = second_enable_or_load_i;

   // Offset mode counts only after the pin role has been caught.
   assign prog_mode = st_r.cfg_done && (st_r.mode == SFP_MODE_PROG);

   // Pin low in offset mode turns both ports to the offset bank.
   assign load_sel = prog_mode && !pin_hi;

   // An array write needs enable low and pin high in either mode,
   // and is refused while full; the blocked word is simply dropped.
   assign fifo_wr = st_r.cfg_done && wr_req && pin_hi
                    && st_r.full_n;

   // Load low with the first enable low writes the next offset.
   assign ofs_wr = load_sel && wr_req;

   // Load low with both read enables low shows the next offset.
   assign ofs_rd = load_sel && rd_req;

   // A normal read needs stored data and the load not selected.
   assign fifo_rd = st_r.cfg_done && !load_sel && rd_req
                    && st_r.empty_n;

   // The outside party must keep offset reads and writes apart;
   // should both come, the bank takes the write and steps once.

   // Offsets use only the low bits that the depth needs.
   assign empty_ofs = empty_offset[AW-1:0];
   assign full_ofs  = full_offset[AW-1:0];

   // Level at which almost-full turns on.
   assign afull_level = DEPTH_C - {1'b0, full_ofs};

   // Word array; write address and read address from the pointers.
   sfp_store #(
      .DW    (SFP_DATA_W),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_store (
      .clk_i     (clk_i),
      .arst_n_i  (arst_n_i),
      .wr_en_i   (fifo_wr),
      .wr_addr_i (st_r.wptr[AW-1:0]),
      .wr_data_i (write_data_i),
      .rd_addr_i (st_r.rptr[AW-1:0]),
      .rd_data_o (ram_rd_data)
   );

   // Offset registers; loading only ever happens in offset mode.
   sfp_offset_bank u_offsets (
      .clk_i          (clk_i),
      .arst_n_i       (arst_n_i),
      .wr_i           (ofs_wr),
      .rd_i           (ofs_rd),
      .wr_data_i      (write_data_i[SFP_OFFS_W-1:0]),
      .rd_data_o      (ofs_rd_data),
      .empty_offset_o (empty_offset),
      .full_offset_o  (full_offset)
   );

   // Pointer advance. They carry one spare bit so that full and
   // empty differ although the address bits are equal in both.
   always_comb begin
      wptr_nxt = st_r.wptr;
      rptr_nxt = st_r.rptr;
      if (fifo_wr) begin
         wptr_nxt = st_r.wptr + CW'(1);
      end
      if (fifo_rd) begin
         rptr_nxt = st_r.rptr + CW'(1);
      end
      count_nxt = wptr_nxt - rptr_nxt;
   end

   // Next state: role capture, pointers, output word and flags.
   always_comb begin
      st_nxt = st_r;

      // The pin role is taken once, at the first edge after the
      // release; no port is allowed into the reset branch itself.
      if (!st_r.cfg_done) begin
         st_nxt.cfg_done = 1'b1;
         if (pin_hi) begin
            st_nxt.mode = SFP_MODE_TWO_WE;
         end else begin
            st_nxt.mode = SFP_MODE_PROG;
         end
      end

      st_nxt.wptr = wptr_nxt;
      st_nxt.rptr = rptr_nxt;

      // Output register takes a word, an offset, or holds.
      if (fifo_rd) begin
         st_nxt.rd_data = ram_rd_data;
      end else if (ofs_rd) begin
         st_nxt.rd_data = {{(SFP_DATA_W - SFP_OFFS_W){1'b0}},
                           ofs_rd_data};
      end else begin
         st_nxt.rd_data = st_r.rd_data;
      end

      // Full: stored words equal the depth. A read on a full array
      // lowers the count, so the flag rises at that same edge.
      st_nxt.full_n = (count_nxt != DEPTH_C);

      // Empty: pointers equal.
      st_nxt.empty_n = (wptr_nxt != rptr_nxt);

      // Almost-full: fill has reached depth minus the full offset.
      st_nxt.afull_n = (count_nxt < afull_level);

      // Almost-empty: fill at or below the empty offset.
      st_nxt.aempty_n = (count_nxt > {1'b0, empty_ofs});
   end

   // State register; all flags and pointers take constants here.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_r.cfg_done <= 1'b0;
         st_r.mode     <= SFP_MODE_PROG;
         st_r.wptr     <= '0;
         st_r.rptr     <= '0;
         st_r.rd_data  <= '0;
         st_r.full_n   <= SFP_FULL_N_RST;
         st_r.empty_n  <= SFP_EMPTY_N_RST;
         st_r.afull_n  <= SFP_AFULL_N_RST;
         st_r.aempty_n <= SFP_AEMPTY_N_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Every output comes straight from the state register.
   assign read_data_o           = st_r.rd_data;
   assign full_flag_n_o         = st_r.full_n;
   assign empty_flag_n_o        = st_r.empty_n;
   assign almost_full_flag_n_o  = st_r.afull_n;
   assign almost_empty_flag_n_o = st_r.aempty_n;

endmodule // sfp_fifo

`default_nettype wire

// ### sfp_fifo_properties.sv
// Purpose: Port-level checks of the flag FIFO.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to every sfp_fifo instance.
`default_nettype none
module sfp_chk #(
   parameter int unsigned DEPTH = 64
) (
   input wire logic       clk_i,
   input wire logic       arst_n_i,
   input wire logic       first_write_enable_n_i,
   input wire logic       second_enable_or_load_i,
   input wire logic       first_read_enable_n_i,
   input wire logic       second_read_enable_n_i,
   input wire logic [8:0] read_data_o,
   input wire logic       full_flag_n_o,
   input wire logic       empty_flag_n_o,
   input wire logic       almost_full_flag_n_o,
   input wire logic       almost_empty_flag_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // A read needs both enables low.
   wire logic rd = !first_read_enable_n_i && !second_read_enable_n_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   property p_rst;
      $rose(arst_n_i) |-> full_flag_n_o && almost_full_flag_n_o &&
         !empty_flag_n_o && !almost_empty_flag_n_o && read_data_o == 9'h000;
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   property p_ff_hold;
      !full_flag_n_o && !first_write_enable_n_i && !rd |=> !full_flag_n_o;
   endproperty
   a_ff_hold: assert property (p_ff_hold) else $error("full lost");
   property p_ff_rel;
      !full_flag_n_o && rd && second_enable_or_load_i |=> full_flag_n_o;
   endproperty
   a_ff_rel: assert property (p_ff_rel) else $error("full kept");
   property p_ef_hold;
      !empty_flag_n_o && first_write_enable_n_i |=> !empty_flag_n_o;
   endproperty
   a_ef_hold: assert property (p_ef_hold) else $error("empty lost");
   property p_ef_set;
      $past(arst_n_i) && !empty_flag_n_o && !first_write_enable_n_i &&
         second_enable_or_load_i |=> empty_flag_n_o;
   endproperty
   a_ef_set: assert property (p_ef_set) else $error("write lost");
   property p_af;
      !full_flag_n_o |-> !almost_full_flag_n_o;
   endproperty
   a_af: assert property (p_af) else $error("almost full high");
   property p_ae;
      !empty_flag_n_o |-> !almost_empty_flag_n_o;
   endproperty
   a_ae: assert property (p_ae) else $error("almost empty high");
   property p_hold;
      !rd && second_enable_or_load_i |=> $stable(read_data_o);
   endproperty
   a_hold: assert property (p_hold) else $error("output moved");
endmodule // sfp_chk
bind sfp_fifo sfp_chk #(.DEPTH(DEPTH)) u_chk (
   .clk_i, .arst_n_i, .first_write_enable_n_i, .second_enable_or_load_i,
   .first_read_enable_n_i, .second_read_enable_n_i, .read_data_o,
   .full_flag_n_o, .empty_flag_n_o, .almost_full_flag_n_o,
   .almost_empty_flag_n_o
);
`default_nettype wire

// ### sfp_offset_bank.sv
// Purpose: Four 8-bit offset registers behind one cyclic selector.
// Assumes: Caller never writes and reads back in the same cycle.
// Notes:   A write wins when both arrive; the selector steps once.
`default_nettype none

module sfp_offset_bank
   import sfp_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  arst_n_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   input  wire logic [SFP_OFFS_W-1:0] wr_data_i,
   output logic      [SFP_OFFS_W-1:0] rd_data_o,
   output logic      [15:0]           empty_offset_o,
   output logic      [15:0]           full_offset_o
);
   typedef struct packed {
      logic [SFP_OFFS_NUM-1:0][SFP_OFFS_W-1:0] regs;
      sfp_sel_t                                sel;
   } sfp_bank_st_t;

   sfp_bank_st_t st_r;
   sfp_bank_st_t st_nxt;

   // Selector survives the pin going high, so loading resumes in order.
   always_comb begin
      st_nxt = st_r;
      if (wr_i) begin
         st_nxt.regs[st_r.sel] = wr_data_i;
      end
      if (wr_i || rd_i) begin
         st_nxt.sel = sfp_sel_t'(st_r.sel + 2'h1);
      end
   end

   // Defaults and first selector position at reset.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_r.regs[SFP_SEL_EMPTY_LO] <= SFP_EMPTY_LO_RST;
         st_r.regs[SFP_SEL_EMPTY_HI] <= SFP_EMPTY_HI_RST;
         st_r.regs[SFP_SEL_FULL_LO]  <= SFP_FULL_LO_RST;
         st_r.regs[SFP_SEL_FULL_HI]  <= SFP_FULL_HI_RST;
         st_r.sel                    <= SFP_SEL_EMPTY_LO;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd_data_o      = st_r.regs[st_r.sel];
   assign empty_offset_o = {st_r.regs[SFP_SEL_EMPTY_HI],
                            st_r.regs[SFP_SEL_EMPTY_LO]};
   assign full_offset_o  = {st_r.regs[SFP_SEL_FULL_HI],
                            st_r.regs[SFP_SEL_FULL_LO]};

endmodule // sfp_offset_bank

`default_nettype wire

// ### sfp_pkg.sv
// Purpose: Shared constants and types of the programmable-flag FIFO.
// Assumes: One clock serves writer and reader.
// Notes:   Offset defaults give both almost flags a distance of seven.
`default_nettype none

package sfp_pkg;

   // Word and array shape.
   localparam int unsigned SFP_DATA_W   = 9;
   localparam int unsigned SFP_DEPTH    = 64;
   localparam int unsigned SFP_OFFS_W   = 8;
   localparam int unsigned SFP_OFFS_NUM = 4;

   // Offset register reset values.
   localparam logic [7:0] SFP_EMPTY_LO_RST = 8'h07;
   localparam logic [7:0] SFP_EMPTY_HI_RST = 8'h00;
   localparam logic [7:0] SFP_FULL_LO_RST  = 8'h07;
   localparam logic [7:0] SFP_FULL_HI_RST  = 8'h00;

   // Flag levels during reset.
   localparam logic SFP_FULL_N_RST   = 1'b1;
   localparam logic SFP_AFULL_N_RST  = 1'b1;
   localparam logic SFP_EMPTY_N_RST  = 1'b0;
   localparam logic SFP_AEMPTY_N_RST = 1'b0;

   // Offset register order, shared by loading and read-back.
   typedef enum logic [1:0] {
      SFP_SEL_EMPTY_LO,
      SFP_SEL_EMPTY_HI,
      SFP_SEL_FULL_LO,
      SFP_SEL_FULL_HI
   } sfp_sel_t;

   // Role of the dual-purpose pin, fixed at the first edge after reset.
   typedef enum logic {
      SFP_MODE_TWO_WE,
      SFP_MODE_PROG
   } sfp_mode_t;

endpackage : sfp_pkg

`default_nettype wire

// ### sfp_store.sv
// Purpose: Flip-flop word array with one write and one read port.
// Assumes: Read address is used combinationally by the caller.
// Notes:   Cleared at reset so read-back never shows unknowns.
`default_nettype none

module sfp_store #(
   parameter int unsigned DW    = 9,
   parameter int unsigned DEPTH = 64,
   parameter int unsigned AW    = 6
) (
   input  wire logic          clk_i,
   input  wire logic          arst_n_i,
   input  wire logic          wr_en_i,
   input  wire logic [AW-1:0] wr_addr_i,
   input  wire logic [DW-1:0] wr_data_i,
   input  wire logic [AW-1:0] rd_addr_i,
   output logic      [DW-1:0] rd_data_o
);
   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] mem;
   } sfp_store_st_t;

   sfp_store_st_t st_r;
   sfp_store_st_t st_nxt;

   // Only the addressed word changes on a write.
   always_comb begin
      st_nxt = st_r;
      if (wr_en_i) begin
         st_nxt.mem[wr_addr_i] = wr_data_i;
      end
   end

   // State register.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd_data_o = st_r.mem[rd_addr_i];

endmodule // sfp_store

`default_nettype wire

// ### sfp_tb.sv
// Purpose: Self-checking bench of the flag FIFO.
// Assumes: 20 MHz clock, reset held ten cycles.
// Notes:   Flags are compared after every edge.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int D = 64;
   logic       clk;
   logic       arst_n;
   int         err_total;
   int         comparisons;
   int         cyc;
   int         k;
   wire logic [8:0] wd, q;
   wire logic       wen_n, pin, r1_n, r2_n, ff_n, ef_n, af_n, ae_n;
   sfp_agent #(.DEPTH(D)) u_ag (.clk_i(clk), .arst_n_i(arst_n), .wd_o(wd),
      .wen_n_o(wen_n), .pin_o(pin), .first_read_enable_n_o(r1_n), .second_read_enable_n_o(r2_n));
   sfp_fifo #(.DEPTH(D)) u_dut (.clk_i(clk), .arst_n_i(arst_n),
      .write_data_i(wd), .first_write_enable_n_i(wen_n),
      .second_enable_or_load_i(pin), .first_read_enable_n_i(r1_n),
      .second_read_enable_n_i(r2_n), .read_data_o(q), .full_flag_n_o(ff_n),
      .empty_flag_n_o(ef_n), .almost_full_flag_n_o(af_n),
      .almost_empty_flag_n_o(ae_n));
   task automatic chk(input string what, input logic [8:0] e,
                      input logic [8:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("Counts: %0d compared, %0d errors", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic rst(input logic p);
      u_ag.step(1'b1, p, 1'b1, 1'b1, 9'h000);
      arst_n = 1'b0;
      repeat (10) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (2) @(posedge clk); // Pin role is caught first.
   endtask
   always #25 clk = ~clk;
   // Watcher: noted words and flags derived from the count and offsets.
   always @(posedge clk) begin
      int n;
      int m;
      int c;
      #2;
      c = u_ag.cnt;
      n = {u_ag.offs[1], u_ag.offs[0]} % D;
      m = {u_ag.offs[3], u_ag.offs[2]} % D;
      if (u_ag.exp_q.size() > 0)
         chk("word", u_ag.exp_q.pop_front(), q);
      chk("flags", {5'h00, c != D, c < D - m, c != 0, c > n},
          {5'h00, ff_n, af_n, ef_n, ae_n});
   end
   // Hang guard, well above the planned run.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         print_verdict();
      end
   end
   initial begin
      {clk, arst_n, err_total, comparisons, cyc} = '0;
      void'($urandom(21));
      rst(1'b0);
      repeat (4) u_ag.step(1'b1, 1'b0, 1'b0, 1'b0, 9'h000);
      u_ag.step(1'b0, 1'b0, 1'b1, 1'b1, 9'h003);
      u_ag.step(1'b1, 1'b1, 1'b1, 1'b1, 9'h000);
      u_ag.step(1'b1, 1'b0, 1'b1, 1'b1, 9'h0AA);
      u_ag.step(1'b0, 1'b0, 1'b1, 1'b1, 9'h002);
      u_ag.step(1'b0, 1'b0, 1'b1, 1'b1, 9'h005);
      u_ag.step(1'b0, 1'b0, 1'b1, 1'b1, 9'h001);
      repeat (4) u_ag.step(1'b1, 1'b0, 1'b0, 1'b0, 9'h000);
      for (k = 0; k < D + 1; k++)
         u_ag.step(1'b0, 1'b1, 1'b1, 1'b1, 9'($urandom));
      for (k = 0; k < 300 && u_ag.cnt > 0; k++)
         u_ag.step(k > 30, 1'b1, 1'b0, ($urandom % 4) == 0,
                   9'($urandom));
      repeat (2) u_ag.step(1'b1, 1'b1, 1'b0, 1'b0, 9'h000);
      rst(1'b1);
      u_ag.step(1'b0, 1'b0, 1'b1, 1'b1, 9'h001);
      u_ag.step(1'b1, 1'b0, 1'b0, 1'b0, 9'h000);
      repeat (9) u_ag.step(1'b0, 1'b1, 1'b1, 1'b1, 9'($urandom));
      u_ag.step(1'b1, 1'b1, 1'b1, 1'b1, 9'h1FF);
      repeat (10) u_ag.step(1'b1, 1'b0, 1'b0, 1'b0, 9'h000);
      repeat (3) @(posedge clk);
      print_verdict();
   end
endmodule // tb
`default_nettype wire
